// *** ddrsw_params.svh ***
// Constants for the DDR burst-of-two SRAM port model
`ifndef DDRSW_PARAMS_SVH
`define DDRSW_PARAMS_SVH
`define DDRSW_DW        18
`define DDRSW_LANE_W    9
`define DDRSW_LANES     2
`define DDRSW_AW        22
`define DDRSW_DEPTH     (1 << `DDRSW_AW)
`define DDRSW_CLK_NS    4
`define DDRSW_STOP_NS   30
`define DDRSW_STOP_CYC  ((`DDRSW_STOP_NS + `DDRSW_CLK_NS - 1) / `DDRSW_CLK_NS)
`define DDRSW_LOCK_US   20
`define DDRSW_LOCK_CYC  (`DDRSW_LOCK_US * 1000 / `DDRSW_CLK_NS)
`define DDRSW_ZQ_PERIOD 1024
`define DDRSW_ZQ_W      10
`define DDRSW_CNT_W     16
`define DDRSW_SYNC_W    3
`endif

// *** ddrsw_pkg.sv ***
// Types shared by the DDR SRAM port model
package ddrsw_pkg;
	typedef enum logic [1:0] {
		ddrsw_lat_one = 2'h1,
		ddrsw_lat_two = 2'h2
	} ddrsw_lat_type;
endpackage : ddrsw_pkg

// *** ddrsw_clk_mon.sv ***
// Input clock sampler: edge finder, stop detector and PLL lock timer
`timescale 1ns/1ps
`include "ddrsw_params.svh"
module ddrsw_clk_mon
	import ddrsw_pkg::*;
#(
	parameter int unsigned LOCK_CYC = `DDRSW_LOCK_CYC // Lock time, sys cycles
) (
	input  wire logic sys_clk_i, // System clock
	input  wire logic sys_rst_i, // Async reset, high
	input  wire logic k_i,       // Positive input clock pin
	input  wire logic k_n_i,     // Negative input clock pin
	input  wire logic pll_en_i,  // Synchronised PLL enable
	output logic      k_rise_o,  // K rising edge seen
	output logic      kn_rise_o, // K# rising edge seen
	output logic      k_lvl_o,   // Synchronised K level
	output logic      kn_lvl_o,  // Synchronised K# level
	output logic      locked_o   // PLL lock reached
);
	localparam int CW = `DDRSW_CNT_W;
	localparam logic [CW-1:0] STOP_V = CW'(`DDRSW_STOP_CYC);
	localparam logic [CW-1:0] LOCK_V = CW'(LOCK_CYC);

	logic [`DDRSW_SYNC_W-1:0] k_sh_r, k_sh_nxt;
	logic [`DDRSW_SYNC_W-1:0] kn_sh_r, kn_sh_nxt;
	logic [CW-1:0]            stop_r, stop_nxt;
	logic [CW-1:0]            lock_r, lock_nxt;
	logic                     stopped;

	// Stage 0 feeds stage 1 only; stage 2 is the previous level
	assign k_lvl_o   = k_sh_r[1];
	assign kn_lvl_o  = kn_sh_r[1];
	assign k_rise_o  = k_sh_r[1] & ~k_sh_r[2];
	assign kn_rise_o = kn_sh_r[1] & ~kn_sh_r[2];
	assign stopped   = (stop_r == STOP_V);
	assign locked_o  = (lock_r == LOCK_V);

	always_comb begin
		k_sh_nxt  = {k_sh_r[1:0], k_i};
		kn_sh_nxt = {kn_sh_r[1:0], k_n_i};
		stop_nxt  = stop_r;
		lock_nxt  = lock_r;
		if (k_rise_o)
			stop_nxt = '0;
		else if (!stopped)
			stop_nxt = stop_r + 1'b1;
		// A gap of more than 8 sys cycles (32 ns) without a K rise restarts the lock timer [R18]
		if (!pll_en_i || stopped)
			lock_nxt = '0;
		else if (!locked_o)
			lock_nxt = lock_r + 1'b1; // [R17]
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			k_sh_r  <= '0;
			kn_sh_r <= '0;
			stop_r  <= '0;
			lock_r  <= '0;
		end else begin
			k_sh_r  <= k_sh_nxt;
			kn_sh_r <= kn_sh_nxt;
			stop_r  <= stop_nxt;
			lock_r  <= lock_nxt;
		end
	end

	property p_stop_unlock;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		stopped |=> (lock_r == '0);
	endproperty
	a_stop_unlock: assert property (p_stop_unlock) // [R18]
		else $error("lock timer not cleared after clock stop");

	property p_lock_hold;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		locked_o && pll_en_i && !stopped |=> locked_o;
	endproperty
	a_lock_hold: assert property (p_lock_hold) // [R17]
		else $error("lock lost while clock stable");
endmodule : ddrsw_clk_mon

// *** ddrsw_top.sv ***
// DDR burst-of-two SRAM port: write path, read path, echo clocks
// Contract
// [R01] Write: direction low, load low at K
// [R02] First word captured at next K rise
// [R03] Second word at K# rise, commit 36 bits
// [R04] New write accepted every K rise
// [R05] Deselected: finish pending write, ignore inputs
// [R06] Lane zero bits 8:0, lane one 17:9
// [R07] Unselected lane keeps stored byte
// [R08] Both lanes off: nothing written
// [R09] Controller may change lanes between words
// [R10] Controller inserts two NOPs read-to-write
// [R11] Write held in registers until next write
// [R12] Read after write bypasses array
// [R13] Controller gives each bank own load
// [R14] Impedance recalibration every 1024 K cycles
// [R15] Two free-running echo clocks follow inputs
// [R16] Read valid rises half cycle early
// [R17] PLL locks 20 us after stable clock
// [R18] Clock stop 30 ns resets PLL
// [R19] PLL disabled: one-cycle read latency
// [R20] Read word at K t+2, then K#
// [R21] Second word uses address plus one
// [R22] Power-up deselected, outputs high impedance
// [R23] Stopped clocks hold outputs
// [R24] NOP: tri-state after next K rise
// [R25] Controls registered only at K rise
`timescale 1ns/1ps
`include "ddrsw_params.svh"
module ddrsw_top
	import ddrsw_pkg::*;
#(
	parameter int unsigned LOCK_CYC = `DDRSW_LOCK_CYC // PLL lock, sys cycles
) (
	input  wire logic                     sys_clk_i,            // 250 MHz clock
	input  wire logic                     sys_rst_i,            // Async reset, high
	input  wire logic                     k_i,                  // Positive input clock
	input  wire logic                     k_n_i,                // Negative input clock
	input  wire logic                     load_select_n_i,      // Command strobe, low
	input  wire logic                     rw_i,                 // High read, low write
	input  wire logic [`DDRSW_AW-1:0]     addr_i,               // Burst address
	input  wire logic [`DDRSW_LANES-1:0]  byte_lane_select_n_i, // Lane selects, low
	input  wire logic                     pll_disable_n_i,      // Low turns PLL off
	input  wire logic [`DDRSW_DW-1:0]     dq_i,                 // Data pin input
	output logic      [`DDRSW_DW-1:0]     dq_o,                 // Data pin output
	output logic                          dq_oe_o,              // Data pin enable
	output logic                          echo_clock_pos_o,     // Echo of K
	output logic                          echo_clock_neg_o,     // Echo of K#
	output logic                          read_valid_flag_o,    // Read data valid
	output logic                          pll_locked_o,         // PLL lock status
	output logic                          imp_cal_o             // Recalibration pulse
);
	localparam int DW = `DDRSW_DW;
	localparam int AW = `DDRSW_AW;
	localparam int NL = `DDRSW_LANES;
	localparam int LW = `DDRSW_LANE_W;
	localparam int IW = AW + DW + NL + 3;
	localparam logic [`DDRSW_ZQ_W-1:0] ZQ_LAST = `DDRSW_ZQ_W'(`DDRSW_ZQ_PERIOD - 1);

	logic [DW-1:0] mem [0:`DDRSW_DEPTH-1];

	// Pin inputs, two flip-flops deep, aligned with the clock sampler
	logic [IW-1:0] in_s1_r, in_s2_r;
	logic          ld_s, rw_s, pdn_s;
	logic [AW-1:0] addr_s;
	logic [DW-1:0] dq_s;
	logic [NL-1:0] bls_s;
	assign {ld_s, rw_s, pdn_s, addr_s, dq_s, bls_s} = in_s2_r;

	logic k_rise, kn_rise, k_lvl, kn_lvl, mon_lock;

	ddrsw_clk_mon #(
		.LOCK_CYC  (LOCK_CYC)
	) u_clk_mon (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.k_i       (k_i),
		.k_n_i     (k_n_i),
		.pll_en_i  (pdn_s),
		.k_rise_o  (k_rise),
		.kn_rise_o (kn_rise),
		.k_lvl_o   (k_lvl),
		.kn_lvl_o  (kn_lvl),
		.locked_o  (mon_lock)
	);

	// Write pipeline and posted-write registers
	logic          wr_due_r, wr_due_nxt, w1_due_r, w1_due_nxt;
	logic [AW-1:0] wr_addr_r, wr_addr_nxt, cur_addr_r, cur_addr_nxt;
	logic [DW-1:0] wd0_r, wd0_nxt;
	logic [NL-1:0] wm0_r, wm0_nxt;
	logic          post_v_r, post_v_nxt;
	logic [AW-1:0] post_addr_r, post_addr_nxt, post_a1;
	logic [DW-1:0] post_d0_r, post_d0_nxt, post_d1_r, post_d1_nxt;
	logic [NL-1:0] post_m0_r, post_m0_nxt, post_m1_r, post_m1_nxt;
	// Read pipeline and output stage
	logic          rd1_v_r, rd1_v_nxt, rd2_v_r, rd2_v_nxt, w1out_r, w1out_nxt;
	logic [AW-1:0] rd1_a_r, rd1_a_nxt, rd2_a_r, rd2_a_nxt, out_a_r, out_a_nxt;
	logic [AW-1:0] fire_a, out_a1;
	logic [DW-1:0] dq_nxt;
	logic          oe_nxt, vld_nxt, lock_nxt, cal_nxt;
	logic [`DDRSW_ZQ_W-1:0] zq_r, zq_nxt;
	logic          wr_cmd, rd_cmd, fire_now, commit;
	ddrsw_lat_type lat;

	assign post_a1 = post_addr_r + 1'b1;
	assign out_a1  = out_a_r + 1'b1;
	assign lat     = pdn_s ? ddrsw_lat_two : ddrsw_lat_one;          // [R19]
	assign fire_now = (lat == ddrsw_lat_two) ? rd2_v_r : rd1_v_r;    // [R20]
	assign fire_a   = (lat == ddrsw_lat_two) ? rd2_a_r : rd1_a_r;
	assign wr_cmd  = k_rise && !ld_s && !rw_s;                        // [R01] [R25]
	assign rd_cmd  = k_rise && !ld_s && rw_s;                         // [R05]
	// Posted write reaches the array at the next write, before that one posts
	assign commit  = post_v_r && (wr_cmd || (kn_rise && w1_due_r));  // [R11]

	// Per-lane merge; a cleared lane keeps the old byte
	function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
			input logic [DW-1:0] new_w, input logic [NL-1:0] en);
		logic [DW-1:0] r;
		r = old_w;
		for (int i = 0; i < NL; i++) begin
			if (en[i])
				r[i*LW +: LW] = new_w[i*LW +: LW]; // [R06] [R07] [R08]
		end
		return r;
	endfunction : lane_merge

	// Array word with the posted write laid over it
	function automatic logic [DW-1:0] rd_word(input logic [AW-1:0] a);
		logic [DW-1:0] w;
		w = mem[a];
		if (post_v_r && a == post_addr_r)
			w = lane_merge(w, post_d0_r, post_m0_r); // [R12]
		else if (post_v_r && a == post_a1)
			w = lane_merge(w, post_d1_r, post_m1_r); // [R12]
		return w;
	endfunction : rd_word

	always_comb begin
		wr_due_nxt    = wr_due_r;
		wr_addr_nxt   = wr_addr_r;
		w1_due_nxt    = w1_due_r;
		cur_addr_nxt  = cur_addr_r;
		wd0_nxt       = wd0_r;
		wm0_nxt       = wm0_r;
		post_v_nxt    = post_v_r;
		post_addr_nxt = post_addr_r;
		post_d0_nxt   = post_d0_r;
		post_m0_nxt   = post_m0_r;
		post_d1_nxt   = post_d1_r;
		post_m1_nxt   = post_m1_r;
		rd1_v_nxt     = rd1_v_r;
		rd1_a_nxt     = rd1_a_r;
		rd2_v_nxt     = rd2_v_r;
		rd2_a_nxt     = rd2_a_r;
		out_a_nxt     = out_a_r;
		w1out_nxt     = w1out_r;
		dq_nxt        = dq_o;
		oe_nxt        = dq_oe_o;
		vld_nxt       = read_valid_flag_o;
		zq_nxt        = zq_r;
		cal_nxt       = 1'b0;
		lock_nxt      = mon_lock;
		// Only the lock status moves without a K edge, so stopped clocks hold all outputs except pll_locked_o [R23]
		if (k_rise) begin
			rd1_v_nxt = rd_cmd;
			rd1_a_nxt = addr_s;
			rd2_v_nxt = rd1_v_r;
			rd2_a_nxt = rd1_a_r;
			if (fire_now) begin
				dq_nxt    = rd_word(fire_a);  // [R20] [R21]
				oe_nxt    = 1'b1;
				vld_nxt   = 1'b1;
				out_a_nxt = fire_a;
				w1out_nxt = 1'b1;
			end else begin
				oe_nxt    = 1'b0;             // [R24]
				vld_nxt   = 1'b0;
				w1out_nxt = 1'b0;
			end
			if (wr_due_r) begin
				wd0_nxt      = dq_s;          // [R02]
				wm0_nxt      = ~bls_s;        // [R06] [R09]
				cur_addr_nxt = wr_addr_r;
			end
			w1_due_nxt  = wr_due_r;
			wr_due_nxt  = wr_cmd;             // [R04]
			if (wr_cmd)
				wr_addr_nxt = addr_s;         // [R01]
			if (commit)
				post_v_nxt = 1'b0;            // [R11]
			zq_nxt = zq_r + 1'b1;
			cal_nxt = (zq_r == ZQ_LAST);      // [R14]
		end
		if (kn_rise) begin
			if (w1_due_r) begin
				post_v_nxt    = 1'b1;         // [R03]
				post_addr_nxt = cur_addr_r;
				post_d0_nxt   = wd0_r;
				post_m0_nxt   = wm0_r;
				post_d1_nxt   = dq_s;
				post_m1_nxt   = ~bls_s;       // [R09]
				w1_due_nxt    = 1'b0;
			end
			if (w1out_r) begin
				dq_nxt    = rd_word(out_a1);  // [R21]
				w1out_nxt = 1'b0;
			end
			// Raised half a cycle before the first word of the next burst
			vld_nxt = fire_now || w1out_r;    // [R16]
		end
	end

	// Array updates: no reset, contents are undefined at power-up
	always_ff @(posedge sys_clk_i) begin
		if (commit) begin
			mem[post_addr_r] <= lane_merge(mem[post_addr_r], post_d0_r, post_m0_r); // [R03]
			mem[post_a1]     <= lane_merge(mem[post_a1], post_d1_r, post_m1_r);     // [R07]
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_s1_r           <= '0;
			in_s2_r           <= '0;
			wr_due_r          <= 1'b0;
			wr_addr_r         <= '0;
			w1_due_r          <= 1'b0;
			cur_addr_r        <= '0;
			wd0_r             <= '0;
			wm0_r             <= '0;
			post_v_r          <= 1'b0;
			post_addr_r       <= '0;
			post_d0_r         <= '0;
			post_m0_r         <= '0;
			post_d1_r         <= '0;
			post_m1_r         <= '0;
			rd1_v_r           <= 1'b0;
			rd1_a_r           <= '0;
			rd2_v_r           <= 1'b0;
			rd2_a_r           <= '0;
			out_a_r           <= '0;
			w1out_r           <= 1'b0;
			dq_o              <= '0;
			dq_oe_o           <= 1'b0;    // [R22]
			read_valid_flag_o <= 1'b0;
			echo_clock_pos_o  <= 1'b0;
			echo_clock_neg_o  <= 1'b0;
			pll_locked_o      <= 1'b0;
			imp_cal_o         <= 1'b0;
			zq_r              <= '0;
		end else begin
			in_s1_r           <= {load_select_n_i, rw_i, pll_disable_n_i, addr_i, dq_i,
				byte_lane_select_n_i};
			in_s2_r           <= in_s1_r;
			wr_due_r          <= wr_due_nxt;
			wr_addr_r         <= wr_addr_nxt;
			w1_due_r          <= w1_due_nxt;
			cur_addr_r        <= cur_addr_nxt;
			wd0_r             <= wd0_nxt;
			wm0_r             <= wm0_nxt;
			post_v_r          <= post_v_nxt;
			post_addr_r       <= post_addr_nxt;
			post_d0_r         <= post_d0_nxt;
			post_m0_r         <= post_m0_nxt;
			post_d1_r         <= post_d1_nxt;
			post_m1_r         <= post_m1_nxt;
			rd1_v_r           <= rd1_v_nxt;
			rd1_a_r           <= rd1_a_nxt;
			rd2_v_r           <= rd2_v_nxt;
			rd2_a_r           <= rd2_a_nxt;
			out_a_r           <= out_a_nxt;
			w1out_r           <= w1out_nxt;
			dq_o              <= dq_nxt;
			dq_oe_o           <= oe_nxt;
			read_valid_flag_o <= vld_nxt;
			echo_clock_pos_o  <= k_lvl;   // [R15]
			echo_clock_neg_o  <= kn_lvl;  // [R15]
			pll_locked_o      <= lock_nxt;
			imp_cal_o         <= cal_nxt;
			zq_r              <= zq_nxt;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_wr_cmd;
		k_rise && !ld_s && !rw_s;
	endsequence

	property p_wr_start;
		s_wr_cmd |=> wr_due_r && wr_addr_r == $past(addr_s);
	endproperty
	a_wr_start: assert property (p_wr_start) // [R01]
		else $error("write command not registered");

	property p_d0_cap;
		k_rise && wr_due_r |=> w1_due_r && wd0_r == $past(dq_s) && wm0_r == ~$past(bls_s);
	endproperty
	a_d0_cap: assert property (p_d0_cap) // [R02]
		else $error("first write word not captured");

	property p_post;
		kn_rise && w1_due_r |=> post_v_r && post_addr_r == $past(cur_addr_r)
			&& post_d1_r == $past(dq_s);
	endproperty
	a_post: assert property (p_post) // [R03]
		else $error("second write word not posted");

	property p_post_hold;
		post_v_r && !wr_cmd && !(kn_rise && w1_due_r)
			|=> post_v_r && post_addr_r == $past(post_addr_r);
	endproperty
	a_post_hold: assert property (p_post_hold) // [R11]
		else $error("posted write lost before next write");

	property p_commit;
		wr_cmd && post_v_r && !kn_rise |=> !post_v_r;
	endproperty
	a_commit: assert property (p_commit) // [R11]
		else $error("posted write not committed at next write");

	property p_bypass;
		k_rise && fire_now && post_v_r && fire_a == post_addr_r && (&post_m0_r)
			|=> dq_o == $past(post_d0_r) && dq_oe_o;
	endproperty
	a_bypass: assert property (p_bypass) // [R12]
		else $error("read missed newest written data");

	property p_tristate;
		k_rise && !fire_now |=> !dq_oe_o && !read_valid_flag_o;
	endproperty
	a_tristate: assert property (p_tristate) // [R24]
		else $error("outputs not released after idle K rise");

	property p_vld_early;
		kn_rise && fire_now |=> read_valid_flag_o && !(dq_oe_o && w1out_r);
	endproperty
	a_vld_early: assert property (p_vld_early) // [R16]
		else $error("read valid not raised ahead of data");

	property p_lat;
		k_rise && rd2_v_r && pdn_s |=> dq_oe_o && out_a_r == $past(rd2_a_r);
	endproperty
	a_lat: assert property (p_lat) // [R20]
		else $error("read data not driven at second K rise");

	property p_cal;
		k_rise && zq_r == ZQ_LAST |=> imp_cal_o ##1 !imp_cal_o;
	endproperty
	a_cal: assert property (p_cal) // [R14]
		else $error("impedance recalibration pulse wrong");
endmodule : ddrsw_top

// *** ddrsw_ctrl_model.sv ***
// Memory controller model: input clocks, commands, write data, read capture
`timescale 1ns/1ps
`include "ddrsw_params.svh"
module ddrsw_ctrl_model import ddrsw_pkg::*; (
	input  wire logic                 lat_two_i, // Read latency two when high
	input  wire logic                 stop_i,    // Hold the input clocks still
	input  wire logic [`DDRSW_DW-1:0] dq_i,      // Device read data
	input  wire logic                 dq_oe_i,   // Device drives data
	input  wire logic                 valid_i,   // Read valid flag
	output logic                      k_o,       // Positive input clock
	output logic                      k_n_o,     // Negative input clock
	output logic                      ld_n_o,    // Command strobe, low
	output logic                      rw_o,      // High read, low write
	output logic [`DDRSW_AW-1:0]      addr_o,    // Burst address
	output logic [1:0]                lane_n_o,  // Lane selects, low
	output logic [`DDRSW_DW-1:0]      dq_o       // Write data
);
	typedef struct packed {
		logic                 ld_n;
		logic                 rw;
		logic [`DDRSW_AW-1:0] a;
		logic                 dv;
		logic [`DDRSW_DW-1:0] d0;
		logic [1:0]           m0;
		logic [`DDRSW_DW-1:0] d1;
		logic [1:0]           m1;
	} ddrsw_slot_type;
	ddrsw_slot_type q[$];    // Queued K cycles
	ddrsw_slot_type s;       // Cycle being driven
	ddrsw_slot_type pend;    // Write data for the next cycle
	logic [2:0]     rd_pipe; // Reads of the last three K rises
	logic [20:0]    got[$];  // Captured valid, early enable, enable, data

	function automatic void wdata(input logic [17:0] d0, input logic [1:0] m0,
			input logic [17:0] d1, input logic [1:0] m1);
		pend = '{1'h1, 1'h0, '0, 1'h1, d0, m0, d1, m1};
	endfunction : wdata

	function automatic void cmd(input logic ld_n, input logic rw, input logic [21:0] a);
		q.push_back('{ld_n, rw, a, pend.dv, pend.d0, pend.m0, pend.d1, pend.m1});
		pend.dv = 1'h0;
	endfunction : cmd

	task automatic word(input logic dv, input logic [17:0] d, input logic [1:0] m);
		if (dv) begin
			dq_o = d;
			lane_n_o = m;
		end else begin
			dq_o = ~dq_o; // Released bus must not look like stale data
			lane_n_o = ~lane_n_o;
		end
	endtask : word

	task automatic capture();
		logic v;
		logic oe;
		#6;
		v = valid_i;
		oe = dq_oe_i;
		#16;
		got.push_back({v, oe, dq_oe_i, dq_i});
		#16;
		got.push_back({valid_i, dq_oe_i, dq_oe_i, dq_i});
	endtask : capture

	initial begin
		k_o = 1'h0;
		k_n_o = 1'h1;
		ld_n_o = 1'h1;
		rw_o = 1'h0;
		addr_o = '0;
		lane_n_o = 2'h3;
		dq_o = '0;
		rd_pipe = '0;
		pend = '0;
		#3;
		forever begin
			s = '0;
			s.ld_n = 1'h1;
			if (q.size() != 0)
				s = q.pop_front();
			#8;
			ld_n_o = s.ld_n; // One bank, its own strobe
			rw_o = s.ld_n ? ~rw_o : s.rw;
			addr_o = s.ld_n ? ~addr_o : s.a;
			word(s.dv, s.d0, s.m0);
			#8;
			while (stop_i) #8; // Both clocks stand still, K low
			k_o = 1'h1;
			k_n_o = 1'h0;
			rd_pipe = {rd_pipe[1:0], !s.ld_n && s.rw};
			if (lat_two_i ? rd_pipe[2] : rd_pipe[1])
				fork capture(); join_none
			#8;
			word(s.dv, s.d1, s.m1); // Lanes may differ between words
			#8;
			k_o = 1'h0;
			k_n_o = 1'h1;
		end
	end
endmodule : ddrsw_ctrl_model

// *** test_ddr_burst2_sram_write_path.sv ***
// Testbench for the DDR burst-of-two SRAM port
`timescale 1ns/1ps
`include "ddrsw_params.svh"
module test_ddr_burst2_sram_write_path import ddrsw_pkg::*;;
	localparam int unsigned LOCK = 64;         // Short lock time keeps the run brief
	localparam logic [21:0] BASE = 22'h000100;
	logic        sys_clk, sys_rst, pll_disable_n, stop, k, k_n, ld_n, rw;
	logic        dq_oe, echo_pos, echo_neg, valid, locked, imp_cal;
	logic [21:0] addr;
	logic [1:0]  lane_n;
	logic [17:0] dq_w, dq_r;
	logic [17:0] mem [logic [21:0]];
	logic [20:0] exp_q[$];
	int          mismatches, checked, kcnt;

	ddrsw_top #(.LOCK_CYC(LOCK)) uut (
		.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .k_i(k), .k_n_i(k_n),
		.load_select_n_i(ld_n), .rw_i(rw), .addr_i(addr), .byte_lane_select_n_i(lane_n),
		.pll_disable_n_i(pll_disable_n), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe),
		.echo_clock_pos_o(echo_pos), .echo_clock_neg_o(echo_neg),
		.read_valid_flag_o(valid), .pll_locked_o(locked), .imp_cal_o(imp_cal));
	ddrsw_ctrl_model ctrl (
		.lat_two_i(pll_disable_n), .stop_i(stop), .dq_i(dq_r), .dq_oe_i(dq_oe),
		.valid_i(valid), .k_o(k), .k_n_o(k_n), .ld_n_o(ld_n), .rw_o(rw),
		.addr_o(addr), .lane_n_o(lane_n), .dq_o(dq_w));

	always #2 sys_clk = ~sys_clk;
	always @(posedge k) kcnt++;

	task automatic check(input string name, input logic [20:0] e, input logic [20:0] g);
		checked++;
		if (e !== g) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask : check

	function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] d,
			input logic [1:0] m);
		merge = old;
		if (!m[0]) merge[8:0] = d[8:0];
		if (!m[1]) merge[17:9] = d[17:9];
	endfunction : merge

	task automatic wr(input logic [21:0] a, input logic [17:0] d0, input logic [1:0] m0,
			input logic [17:0] d1, input logic [1:0] m1);
		ctrl.cmd(1'h0, 1'h0, a);
		ctrl.wdata(d0, m0, d1, m1);
		mem[a] = merge(mem[a], d0, m0);
		mem[a + 22'h1] = merge(mem[a + 22'h1], d1, m1);
	endtask : wr

	task automatic rd(input logic [21:0] a, input logic first);
		ctrl.cmd(1'h0, 1'h1, a);
		exp_q.push_back({1'h1, ~first, 1'h1, mem[a]});
		exp_q.push_back({3'h7, mem[a + 22'h1]});
	endtask : rd

	task automatic nop(input int n);
		repeat (n) ctrl.cmd(1'h1, 1'h0, '0);
	endtask : nop

	task automatic drain(input string name);
		int n;
		n = 0;
		while (ctrl.q.size() != 0 && n < 100) begin
			@(posedge k);
			n++;
		end
		repeat (4) @(posedge k);
		#24;
		check({name, " idle"}, 21'h0, {valid, dq_oe, 19'h0});
		while (exp_q.size() != 0 && ctrl.got.size() != 0)
			check({name, " read"}, exp_q.pop_front(), ctrl.got.pop_front());
		check({name, " count"}, 21'(exp_q.size()), 21'(ctrl.got.size()));
		$display("Test %s done", name);
	endtask : drain

	task automatic t_power;
		check("power idle", 21'h0, {dq_oe, valid, 19'h0});
		@(posedge k);
		#22;
		check("echo k", 21'h2, {19'h0, echo_pos, echo_neg});
		#16;
		check("echo kn", 21'h1, {19'h0, echo_pos, echo_neg});
		$display("Test power done");
	endtask : t_power

	task automatic t_write_read;
		wr(BASE, 18'h2A5C3, 2'h0, 18'h15A3C, 2'h0);
		wr(BASE + 22'h2, 18'h3F00F, 2'h0, 18'h0C0F3, 2'h0);
		rd(BASE, 1'h1);
		rd(BASE + 22'h1, 1'h0);
		nop(3);
		drain("write_read");
	endtask : t_write_read

	task automatic t_lanes;
		nop(2);
		wr(BASE, 18'h00155, 2'h2, 18'h3FFFF, 2'h3);
		wr(BASE + 22'h2, 18'h2AA00, 2'h1, 18'h12345, 2'h0);
		nop(1);
		rd(BASE, 1'h1);
		rd(BASE + 22'h2, 1'h0);
		nop(3);
		drain("lanes");
	endtask : t_lanes

	task automatic t_lat1;
		pll_disable_n = 1'h0;
		#40;
		check("lock off", 21'h0, {20'h0, locked});
		wr(BASE + 22'h4, 18'h1E1E1, 2'h0, 18'h21212, 2'h0);
		nop(2);
		rd(BASE + 22'h2, 1'h1);
		rd(BASE + 22'h4, 1'h0);
		nop(3);
		drain("latency_one");
		pll_disable_n = 1'h1;
	endtask : t_lat1

	task automatic t_pll;
		logic [20:0] held;
		#(LOCK * 4 + 100);
		check("locked", 21'h1, {20'h0, locked});
		stop = 1'h1;
		#40; // Clocks halt within one K period, outputs settle
		held = {echo_pos, echo_neg, dq_oe, dq_r};
		#80;
		check("stopped hold", held, {echo_pos, echo_neg, dq_oe, dq_r});
		check("stop unlock", 21'h0, {20'h0, locked});
		stop = 1'h0;
		#(LOCK * 4 + 100);
		check("relock", 21'h1, {20'h0, locked});
		$display("Test pll done");
	endtask : t_pll

	task automatic t_cal;
		int n;
		int seen;
		n = 0;
		seen = 0;
		while (seen < 3 && n < 40000) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (imp_cal === 1'h1) begin
				if (seen > 0)
					check("cal spacing", 21'h400, 21'(kcnt));
				seen++;
				kcnt = 0;
			end
		end
		check("cal pulses", 21'h3, 21'(seen));
		$display("Test calibration done");
	endtask : t_cal

	task automatic conclude;
		$display("Checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	initial begin
		sys_clk = 1'h0;
		sys_rst = 1'h1;
		pll_disable_n = 1'h1;
		stop = 1'h0;
		mismatches = 0;
		checked = 0;
		kcnt = 0;
		repeat (20) @(posedge sys_clk);
		#1;
		sys_rst = 1'h0;
		repeat (LOCK - 16) @(posedge sys_clk);
		#1;
		check("early lock", 21'h0, {20'h0, locked});
		t_power;
		t_write_read;
		t_lanes;
		t_lat1;
		t_pll;
		t_cal;
		conclude;
	end

	initial begin
		#300000;
		mismatches++;
		$display("Watchdog expired");
		conclude;
	end
endmodule : test_ddr_burst2_sram_write_path
